// file: rtl/oss_map.vh
// Register offsets, field positions, limits and timing counts for the output sequencer
`ifndef OSS_MAP_VH
`define OSS_MAP_VH
`define OSS_CLK_HZ 100000000
`define OSS_PROC_DELAY_US 270
`define OSS_STEP_US 100
`define OSS_DEGLITCH_US 30
`define OSS_SERVO_MS 90
`define OSS_MIN_RISE_US 250
`define OSS_MAX_FALL_STEPS 13000
`define OSS_MAX_LL_PCT 15
`define OSS_PROC_CYC ((`OSS_PROC_DELAY_US * (`OSS_CLK_HZ / 1000000)))
`define OSS_STEP_CYC ((`OSS_STEP_US * (`OSS_CLK_HZ / 1000000)))
`define OSS_DEGL_CYC ((`OSS_DEGLITCH_US * (`OSS_CLK_HZ / 1000000)))
`define OSS_SERVO_CYC ((`OSS_SERVO_MS * (`OSS_CLK_HZ / 1000)))
`define OSS_MIN_RISE_STEPS (`OSS_MIN_RISE_US / `OSS_STEP_US)
`define OSS_A_CTRL 12'h000
`define OSS_A_VSET 12'h004
`define OSS_A_UV 12'h008
`define OSS_A_OV 12'h00C
`define OSS_A_TON 12'h010
`define OSS_A_TOFF 12'h014
`define OSS_A_RISE 12'h018
`define OSS_A_FALL 12'h01C
`define OSS_A_TMAX 12'h020
`define OSS_A_MODE 12'h024
`define OSS_A_LLP 12'h028
`define OSS_A_OCW 12'h02C
`define OSS_A_STAT 12'h030
`define OSS_A_DAC 12'h034
`define OSS_CTRL_ON 0
`define OSS_MODE_SERVO 6
`define OSS_MODE_RANGE 1
`endif

// file: rtl/oss_channel.v
// Output channel sequencer, power-good, servo and load-line control with APB registers
// Overview of operation
// - Wait a fixed 270us processing delay before any output voltage change starts.
// - Time-based operations advance on a 100us step tick, start within 100us.
// - Zero turn-on or turn-off wait still gives 270us to 370us delay.
// - Bus-commanded changes start the processing delay at the bus transfer end.
// - Assert output_ok above undervoltage plus hysteresis before startup timeout, else fault.
// - Peers share timebase and run line; run, input-on or bus may trigger.
// - Falling output_ok is filtered through a 30us deglitch interval.
// - output_ok drops when outside undervoltage or overvoltage limits, or disabled.
// - Servo enables when bit 6 of pwm_mode_config is set.
// - Every 90ms servo steps the DAC one LSB toward the measured target.
// - Servo eligible only with enable, ramp done, no UV, no OC, zero load-line.
// - Servo engages after startup timeout expires, or at once if limit zero.
// - Load-line percent is reduction at overcurrent_warn_level, capped at 15%.
// - Setpoints are no-load levels; load-line only lowers the output.
// - Load-line enabled disables the servo.
// - Load-line stays active during all ramping including rise.
// - Zero load-line percent disables load-line positioning, reset default zero.
// - Slave phase, feedback_input tied high, disables load-line positioning.
// - Reduction scales linearly with current over the warning level.
// - Ramp-up times below 0.250ms skip the soft-start ramp; the code skips it only below 2 steps (0.200ms).
// - Ramp-down runs when run input falls or bus commands off.
// - Ramp-down duration is capped at 1.3 seconds.
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "oss_map.vh"
module oss_channel #(
   parameter DW = 16,
   parameter PROC_CYC = `OSS_PROC_CYC,
   parameter STEP_CYC = `OSS_STEP_CYC,
   parameter SERVO_CYC = `OSS_SERVO_CYC,
   parameter DEGL_CYC = `OSS_DEGL_CYC
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire run_in,
   input wire input_on_ok,
   input wire timebase_in,
   input wire feedback_input_high,
   input wire [DW-1:0] vout_meas,
   input wire [DW-1:0] iout_meas,
   input wire uv_hyst_ok,
   input wire oc_fault_in,
   output reg [DW-1:0] dac_code,
   output reg output_ok_flag,
   output reg pwm_enable,
   output reg startup_fault
);
   localparam ST_OFF = 3'd0;
   localparam ST_WON = 3'd1;
   localparam ST_RISE = 3'd2;
   localparam ST_REG = 3'd3;
   localparam ST_WOFF = 3'd4;
   localparam ST_FALL = 3'd5;
   localparam ST_PROC = 3'd6;
   reg ctrl_on_q;
   reg [DW-1:0] vset_q, uv_q, ov_q, ocw_q;
   reg [15:0] ton_q, toff_q, rise_q, fall_q, tmax_q;
   reg [7:0] mode_q;
   reg [7:0] llp_q;
   reg [2:0] st_q, st_next_q;
   reg [31:0] pcnt_q;
   reg [15:0] scnt_q, tmax_cnt_q;
   reg tmax_exp_q;
   reg [31:0] tick_cnt_q;
   reg tick_q;
   reg tb_q;
   reg [DW-1:0] target_q, trim_q;
   reg [31:0] servo_cnt_q;
   reg [31:0] degl_q;
   reg go_q, bus_go_q, run_q, on_req_q;
   wire wr_done = psel & penable & pwrite & pready;
   wire in_range = uv_hyst_ok & (vout_meas <= ov_q);
   wire ll_on = (llp_q != 8'h00) & ~feedback_input_high;
   wire [7:0] llp_eff = (llp_q > `OSS_MAX_LL_PCT) ? `OSS_MAX_LL_PCT : llp_q;
   wire [15:0] fall_eff = (fall_q > `OSS_MAX_FALL_STEPS) ? `OSS_MAX_FALL_STEPS : fall_q;
   wire servo_elig = mode_q[`OSS_MODE_SERVO] & (st_q == ST_REG) & uv_hyst_ok & ~oc_fault_in
                   & ~ll_on;
   wire servo_go = servo_elig & (tmax_exp_q | (tmax_q == 16'h0000));
   wire on_req = ctrl_on_q & run_in & input_on_ok;
   // Load-line drop = target * pct * I / (100 * Iwarn), clipped so it never raises output
   wire [DW+23:0] ll_num = target_q * llp_eff * iout_meas;
   wire [DW+7:0] ll_den = ocw_q * 8'd100;
   wire [DW+23:0] ll_drop = (ll_den == 0) ? {(DW+24){1'b0}} : ll_num / ll_den;
   wire [DW-1:0] ll_cut = (ll_drop >= target_q) ? target_q : ll_drop[DW-1:0];
   // Ramp product kept wide so large setpoints do not wrap before the divide
   wire [DW+15:0] rise_prod = vset_q * (scnt_q + 16'h1);
   wire [DW+15:0] rise_quo = rise_prod / rise_q;
   function [31:0] rd_mux;
      input [11:0] a;
      case (a)
         `OSS_A_CTRL: rd_mux = {31'h0, ctrl_on_q};
         `OSS_A_VSET: rd_mux = vset_q;
         `OSS_A_UV: rd_mux = uv_q;
         `OSS_A_OV: rd_mux = ov_q;
         `OSS_A_TON: rd_mux = ton_q;
         `OSS_A_TOFF: rd_mux = toff_q;
         `OSS_A_RISE: rd_mux = rise_q;
         `OSS_A_FALL: rd_mux = fall_q;
         `OSS_A_TMAX: rd_mux = tmax_q;
         `OSS_A_MODE: rd_mux = mode_q;
         `OSS_A_LLP: rd_mux = llp_q;
         `OSS_A_OCW: rd_mux = ocw_q;
         `OSS_A_STAT: rd_mux = {24'h0, servo_go, tmax_exp_q, startup_fault, output_ok_flag,
            pwm_enable, st_q};
         `OSS_A_DAC: rd_mux = dac_code;
         default: rd_mux = 32'h0000_0000;
      endcase
   endfunction
   function valid_addr;
      input [11:0] a;
      valid_addr = (a[1:0] == 2'b00) && (a <= `OSS_A_DAC);
   endfunction
   // APB slave, zero wait states
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_on_q <= 1'b0;
         vset_q <= {DW{1'b0}};
         uv_q <= {DW{1'b0}};
         ov_q <= {DW{1'b1}};
         ocw_q <= {DW{1'b1}};
         ton_q <= 16'h0000;
         toff_q <= 16'h0000;
         rise_q <= 16'h000A;
         fall_q <= 16'h000A;
         tmax_q <= 16'h0000;
         mode_q <= 8'h00;
         llp_q <= 8'h00;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         bus_go_q <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~valid_addr(paddr);
         bus_go_q <= 1'b0;
         if (psel & ~penable & ~pwrite)
            prdata <= rd_mux(paddr);
         if (wr_done & valid_addr(paddr)) begin
            // Transfer end stands in for the serial STOP
            bus_go_q <= (paddr == `OSS_A_CTRL) | (paddr == `OSS_A_VSET);
            case (paddr)
               `OSS_A_CTRL: ctrl_on_q <= pwdata[`OSS_CTRL_ON];
               `OSS_A_VSET: vset_q <= pwdata[DW-1:0];
               `OSS_A_UV: uv_q <= pwdata[DW-1:0];
               `OSS_A_OV: ov_q <= pwdata[DW-1:0];
               `OSS_A_TON: ton_q <= pwdata[15:0];
               `OSS_A_TOFF: toff_q <= pwdata[15:0];
               `OSS_A_RISE: rise_q <= pwdata[15:0];
               `OSS_A_FALL: fall_q <= pwdata[15:0];
               `OSS_A_TMAX: tmax_q <= pwdata[15:0];
               `OSS_A_MODE: mode_q <= pwdata[7:0];
               `OSS_A_LLP: llp_q <= (pwdata[7:0] > `OSS_MAX_LL_PCT) ? 8'h0F : pwdata[7:0];
               `OSS_A_OCW: ocw_q <= pwdata[DW-1:0];
               default: ctrl_on_q <= ctrl_on_q;
            endcase
         end
      end
   end
   // Step tick: local divider, realigned by the shared timebase edge so peers stay in step
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_q <= 32'h0;
         tick_q <= 1'b0;
         tb_q <= 1'b0;
      end else begin
         tb_q <= timebase_in;
         if ((tick_cnt_q == STEP_CYC - 1) | (timebase_in & ~tb_q)) begin
            tick_cnt_q <= 32'h0;
            tick_q <= 1'b1;
         end else begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
            tick_q <= 1'b0;
         end
      end
   end
   // Channel sequencer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= ST_OFF;
         st_next_q <= ST_OFF;
         pcnt_q <= 32'h0;
         scnt_q <= 16'h0;
         target_q <= {DW{1'b0}};
         pwm_enable <= 1'b0;
         run_q <= 1'b0;
         on_req_q <= 1'b0;
         tmax_cnt_q <= 16'h0;
         tmax_exp_q <= 1'b0;
         startup_fault <= 1'b0;
      end else begin
         on_req_q <= on_req;
         run_q <= run_in;
         case (st_q)
            ST_OFF: begin
               if (on_req) begin
                  st_q <= ST_PROC;
                  st_next_q <= ST_WON;
                  pcnt_q <= 32'h0;
                  startup_fault <= 1'b0;
                  tmax_exp_q <= 1'b0;
                  tmax_cnt_q <= 16'h0;
               end
            end
            ST_PROC: begin
               // Fixed processing delay, then wait for step alignment
               if (pcnt_q < PROC_CYC - 1)
                  pcnt_q <= pcnt_q + 32'h1;
               else if (tick_q) begin
                  st_q <= st_next_q;
                  scnt_q <= 16'h0;
                  if (st_next_q == ST_RISE)
                     pwm_enable <= 1'b1;
               end
            end
            ST_WON: begin
               if (!on_req)
                  st_q <= ST_OFF;
               else if (scnt_q >= ton_q) begin
                  st_q <= ST_RISE;
                  pwm_enable <= 1'b1;
                  scnt_q <= 16'h0;
               end else if (tick_q)
                  scnt_q <= scnt_q + 16'h1;
            end
            ST_RISE: begin
               // Off request mid-ramp abandons the ramp at once and starts the processing delay
               if (!on_req) begin
                  st_q <= ST_PROC;
                  st_next_q <= ST_WOFF;
                  pcnt_q <= 32'h0;
               end else if (rise_q < `OSS_MIN_RISE_STEPS) begin
                  target_q <= vset_q;
                  st_q <= ST_REG;
               end else if (tick_q) begin
                  scnt_q <= scnt_q + 16'h1;
                  target_q <= rise_quo[DW-1:0];
                  if (scnt_q + 16'h1 >= rise_q) begin
                     target_q <= vset_q;
                     st_q <= ST_REG;
                  end
               end
            end
            ST_REG: begin
               if (!on_req) begin
                  st_q <= ST_PROC;
                  st_next_q <= ST_WOFF;
                  pcnt_q <= 32'h0;
               end else if (bus_go_q & (target_q != vset_q)) begin
                  st_q <= ST_PROC;
                  st_next_q <= ST_RISE;
                  pcnt_q <= 32'h0;
                  scnt_q <= 16'h0;
               end
            end
            ST_WOFF: begin
               if (scnt_q >= toff_q) begin
                  st_q <= ST_FALL;
                  scnt_q <= 16'h0;
               end else if (tick_q)
                  scnt_q <= scnt_q + 16'h1;
            end
            ST_FALL: begin
               if (fall_eff == 16'h0000 || (tick_q && scnt_q + 16'h1 >= fall_eff)) begin
                  target_q <= {DW{1'b0}};
                  pwm_enable <= 1'b0;
                  st_q <= ST_OFF;
               end else if (tick_q) begin
                  scnt_q <= scnt_q + 16'h1;
                  target_q <= target_q - target_q / (fall_eff - scnt_q);
               end
            end
            default: st_q <= ST_OFF;
         endcase
         // Startup timeout counts in steps from the start of the rise
         if ((st_q == ST_RISE) | (st_q == ST_REG)) begin
            if (tick_q & ~tmax_exp_q & (tmax_q != 16'h0000)) begin
               tmax_cnt_q <= tmax_cnt_q + 16'h1;
               if (tmax_cnt_q + 16'h1 >= tmax_q) begin
                  tmax_exp_q <= 1'b1;
                  if (!output_ok_flag)
                     startup_fault <= 1'b1;
               end
            end
         end
      end
   end
   // Power good: rises at once, falls after the deglitch interval, or at once when disabled or off
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         output_ok_flag <= 1'b0;
         degl_q <= 32'h0;
      end else if (!pwm_enable || st_q == ST_OFF) begin
         output_ok_flag <= 1'b0;
         degl_q <= 32'h0;
      end else if (in_range) begin
         output_ok_flag <= (st_q == ST_RISE) | (st_q == ST_REG) | output_ok_flag;
         degl_q <= 32'h0;
      end else if (output_ok_flag) begin
         if (degl_q >= DEGL_CYC - 1) begin
            output_ok_flag <= 1'b0;
            degl_q <= 32'h0;
         end else
            degl_q <= degl_q + 32'h1;
      end
   end
   // Servo trim, held only while regulating; DAC applies load-line from the target
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trim_q <= {DW{1'b0}};
         servo_cnt_q <= 32'h0;
         dac_code <= {DW{1'b0}};
      end else begin
         if (!servo_go) begin
            servo_cnt_q <= 32'h0;
            if (st_q != ST_REG)
               trim_q <= {DW{1'b0}};
         end else if (servo_cnt_q >= SERVO_CYC - 1) begin
            servo_cnt_q <= 32'h0;
            // One LSB per interval; LSB weight follows the range bit in the analog DAC
            if (vout_meas < target_q)
               trim_q <= trim_q + {{(DW-1){1'b0}}, 1'b1};
            else if (vout_meas > target_q)
               trim_q <= trim_q - {{(DW-1){1'b0}}, 1'b1};
         end else
            servo_cnt_q <= servo_cnt_q + 32'h1;
         if (ll_on)
            dac_code <= target_q - ll_cut;
         else
            dac_code <= target_q + trim_q;
      end
   end
endmodule // oss_channel

// file: testbench/oss_channel_checker.sv
// Port assertions for the output channel sequencer
`timescale 1ns/1ps
module oss_channel_checker #(
   parameter PROC_CYC = 27000,
   parameter STEP_CYC = 10000,
   parameter DEGL_CYC = 3000
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire pready,
   input wire pslverr,
   input wire run_in,
   input wire input_on_ok,
   input wire uv_hyst_ok,
   input wire pwm_enable,
   input wire output_ok_flag
);
   reg ctrl_on_q;
   reg on_prev_q;
   reg [31:0] ton_q;
   reg [31:0] since_q;
   reg [31:0] bad_q;
   wire wr_ok = psel && penable && pready && pwrite && !pslverr;
   // Mirror of the turn-on request, so delays are timed from its edges
   wire on_req = ctrl_on_q && run_in && input_on_ok;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_on_q <= 1'h0;
         on_prev_q <= 1'h0;
         ton_q <= 32'h0;
         since_q <= 32'h0;
         bad_q <= 32'h0;
      end else begin
         if (wr_ok && paddr == 12'h000) begin
            ctrl_on_q <= pwdata[0];
         end
         if (wr_ok && paddr == 12'h010) begin
            ton_q <= pwdata;
         end
         on_prev_q <= on_req;
         since_q <= (on_req != on_prev_q) ? 32'h0 : since_q + 32'h1;
         // Raw bad time, independent of the filter inside the channel
         bad_q <= (!uv_hyst_ok || !pwm_enable) ? bad_q + 32'h1 : 32'h0;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_start_delay: assert property ($rose(pwm_enable) |-> since_q >= PROC_CYC - 3)
      else $error("output enabled too early");
   a_on_cause: assert property ($rose(pwm_enable) |-> on_req)
      else $error("output enabled without a request");
   a_zero_wait: assert property ($rose(pwm_enable) && ton_q == 32'h0 |->
      since_q <= PROC_CYC + STEP_CYC + 3) else $error("zero wait start too late");
   a_off_delay: assert property ($fell(pwm_enable) && !on_req |-> since_q >= PROC_CYC - 3)
      else $error("output disabled too early");
   a_ok_rise: assert property ($rose(output_ok_flag) |-> $past(uv_hyst_ok) && pwm_enable)
      else $error("output ok without cause");
   a_ok_deglitch: assert property ($fell(output_ok_flag) && pwm_enable |-> bad_q >= DEGL_CYC - 3)
      else $error("output ok dropped before the filter time");
   a_ok_drops: assert property (bad_q > DEGL_CYC + 3 |-> !output_ok_flag)
      else $error("output ok held while bad");
   a_pready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   cover property ($rose(pwm_enable));
   cover property ($fell(output_ok_flag) && pwm_enable);
   cover property (pready && pslverr);
endmodule // oss_channel_checker
bind oss_channel oss_channel_checker #(.PROC_CYC(PROC_CYC), .STEP_CYC(STEP_CYC),
   .DEGL_CYC(DEGL_CYC)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .run_in(run_in), .input_on_ok(input_on_ok), .uv_hyst_ok(uv_hyst_ok),
   .pwm_enable(pwm_enable), .output_ok_flag(output_ok_flag));

// file: testbench/oss_peer.sv
// Peer controller model sharing the run line and the step timebase
`timescale 1ns/1ps
module oss_peer #(
   parameter STEP_CYC = 10
) (
   input wire pclk,
   input wire presetn,
   input wire go,
   output reg run_line,
   output reg timebase
);
   integer cnt;
   // Timebase runs free so all peers step on one tick
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 0;
         timebase <= 1'h0;
         run_line <= 1'h0;
      end else begin
         cnt <= (cnt == STEP_CYC - 1) ? 0 : cnt + 1;
         timebase <= (cnt == 0);
         run_line <= go;
      end
   end
endmodule // oss_peer

// file: testbench/oss_channel_tb.sv
// Self-checking bench for the output channel sequencer
`timescale 1ns/1ps
module oss_channel_tb;
   localparam int PROC = 27;
   localparam int STEP = 10;
   localparam int DEGL = 10;
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic go = 1'h0;
   logic on_ok = 1'h0;
   logic uv_ok = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [15:0] vout = 16'h0;
   logic [15:0] iout = 16'h0;
   logic [31:0] seed_a = 32'h0000CCA5;
   logic [31:0] seed_b = 32'h0000CCA5;
   logic [31:0] prdata, rd_q;
   logic [15:0] dac_code;
   logic pready, pslverr, err, run_line, timebase, ok_flag, pwm_en, fault;
   int n_errors = 0;
   int compares = 0;
   int n, ton, i;
   always #5 pclk = ~pclk;
   oss_peer #(.STEP_CYC(STEP)) u_peer (.pclk(pclk), .presetn(presetn), .go(go),
      .run_line(run_line), .timebase(timebase));
   oss_channel #(.PROC_CYC(PROC), .STEP_CYC(STEP), .SERVO_CYC(100), .DEGL_CYC(DEGL)) DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .run_in(run_line), .input_on_ok(on_ok), .timebase_in(timebase),
      .feedback_input_high(1'h0), .vout_meas(vout), .iout_meas(iout), .uv_hyst_ok(uv_ok),
      .oc_fault_in(1'h0), .dac_code(dac_code), .output_ok_flag(ok_flag),
      .pwm_enable(pwm_en), .startup_fault(fault));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   // Noisy readings; kept below the overvoltage limit so only UV can drop the flag
   always @(posedge pclk) begin
      seed_b <= xs(seed_b);
      vout <= {1'h0, seed_b[14:0]};
      iout <= seed_b[31:16];
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      if (n_errors == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) begin
         if (k == 50) begin
            n_errors++;
            conclude;
         end
         k++;
         @(posedge pclk);
      end
      rd_q = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wait_for(input logic which, input logic lvl);
      n = 0;
      while ((which ? ok_flag : pwm_en) !== lvl) begin
         if (n == 4000) begin
            n_errors++;
            conclude;
         end
         n++;
         @(posedge pclk);
      end
   endtask
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'h1;
      on_ok <= 1'h1;
      apb(1'h0, 12'h028, 32'h0);
      chk(rd_q, 32'h0);
      apb(1'h1, 12'h028, 32'h00000014);
      apb(1'h0, 12'h028, 32'h0);
      chk(rd_q, 32'h0000000F);
      apb(1'h0, 12'h03C, 32'h0);
      chk(err, 32'h1);
      chk(rd_q, 32'h0);
      apb(1'h1, 12'h028, 32'h0);
      apb(1'h1, 12'h008, 32'h0);
      apb(1'h1, 12'h00C, 32'h0000FFFF);
      apb(1'h1, 12'h004, 32'h00004000);
      apb(1'h1, 12'h014, 32'h0);
      apb(1'h1, 12'h018, 32'h3);
      apb(1'h1, 12'h01C, 32'h2);
      apb(1'h1, 12'h020, 32'h0);
      // Odd passes turn off by the run line, even passes by the bus
      for (i = 0; i < 4; i++) begin
         ton = (i == 0) ? 0 : int'(seed_a[1:0]);
         seed_a = xs(seed_a);
         go <= 1'h1;
         apb(1'h1, 12'h010, 32'(ton));
         apb(1'h1, 12'h000, 32'h1);
         wait_for(1'h0, 1'h1);
         chk(n >= PROC - 2 + ton * STEP && n <= PROC + (ton + 1) * STEP + 3, 1);
         uv_ok <= 1'h1;
         wait_for(1'h1, 1'h1);
         chk(n <= 4, 1);
         uv_ok <= 1'h0;
         repeat (1 + seed_a[2:0] % 6) @(posedge pclk);
         uv_ok <= 1'h1;
         repeat (DEGL + 3) @(posedge pclk);
         chk(ok_flag, 1);
         uv_ok <= 1'h0;
         wait_for(1'h1, 1'h0);
         chk(n >= DEGL - 1 && n <= DEGL + 4, 1);
         repeat (STEP) @(posedge pclk);
         chk(dac_code, 32'h00004000);
         chk(fault, 1'h0);
         if (i[0]) go <= 1'h0;
         else apb(1'h1, 12'h000, 32'h0);
         wait_for(1'h0, 1'h0);
         chk(n >= PROC - 2 && n <= PROC + 3 * STEP + 4, 1);
         apb(1'h1, 12'h000, 32'h0);
      end
      conclude;
   end
endmodule // oss_channel_tb
